// ==== dv/ctrl_model.sv ====
// Machine controller model: drives input pins, listens on driven pins.
`timescale 1ns/1ps
`default_nettype none
module ctrl_model (
   // Device side
   input  wire logic [3:0] dev_lvl_i,
   input  wire logic [3:0] dev_oe_n_i,
   output logic      [3:0] wire_o,
   // Bench side
   input  wire logic [3:0] drive_i
);
   // Where the device drives a pin the controller only listens.
   always_comb begin
      for (int p = 0; p < 4; p++) begin
         wire_o[p] = dev_oe_n_i[p] ? drive_i[p] : dev_lvl_i[p];
      end
   end
endmodule : ctrl_model
`default_nettype wire

// ==== dv/swio_monitor.sv ====
// Checker for bus handshake, pulses, filter and configuration timing.
`timescale 1ns/1ps
`default_nettype none
module swio_monitor (
   // Clock and reset
   input wire logic                    clk_i,
   input wire logic                    rst_i,
   // Bus
   input wire logic [swio_pkg::AW-1:0] adr_i,
   input wire logic [31:0]             dat_i,
   input wire logic [31:0]             dat_o,
   input wire logic                    we_i,
   input wire logic [3:0]              sel_i,
   input wire logic                    cyc_i,
   input wire logic                    stb_i,
   input wire logic                    ack_o,
   // Block state
   input wire logic                    meas_valid_i,
   input wire logic [3:0]              pin_oe_n_o,
   input wire logic                    trigger_o,
   input wire logic                    teach_o,
   input wire logic                    eval_valid_o
);
   import swio_pkg::*;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic req;
   logic dep_ok;
   assign req = cyc_i && stb_i && !ack_o;
   assign dep_ok = req && we_i && adr_i == ADR_DEPTH && sel_i[1:0] == 2'h3
                   && dat_i[15:0] >= DEPTH_MIN && dat_i[15:0] <= DEPTH_MAX;
   a_ack_next: assert property (req |=> ack_o)
      else $error("bus request not acknowledged next cycle");
   a_ack_pulse: assert property (ack_o |=> !ack_o)
      else $error("acknowledge longer than one cycle");
   a_dat_quiet: assert property (!ack_o |-> dat_o == 32'h0000_0000)
      else $error("read data not zero outside acknowledge");
   a_trig_pulse: assert property (trigger_o |=> !trigger_o)
      else $error("trigger pulse longer than one cycle");
   a_teach_pulse: assert property (teach_o |=> !teach_o)
      else $error("teach pulse longer than one cycle");
   a_eval_cause: assert property ($rose(eval_valid_o)
      |-> $past(meas_valid_i))
      else $error("evaluation without measurement");
   a_depth_clear: assert property (dep_ok && !meas_valid_i
      && !$past(meas_valid_i) |=> !eval_valid_o)
      else $error("depth change kept evaluation");
   a_cfg_timing: assert property ($changed(pin_oe_n_o)
      |-> $past(meas_valid_i) || $past(meas_valid_i, 2))
      else $error("pin direction changed outside measurement");
   property reset_state;
      disable iff (1'b0)
         rst_i |=> !ack_o && pin_oe_n_o == 4'hF && !eval_valid_o;
   endproperty
   a_reset_idle: assert property (reset_state)
      else $error("outputs not idle after reset");
   c_trig: cover property (trigger_o);
   c_teach: cover property (teach_o);
   c_eval: cover property ($rose(eval_valid_o));
endmodule : swio_monitor
bind swio_top swio_monitor u_mon (.clk_i, .rst_i, .adr_i, .dat_i, .dat_o,
   .we_i, .sel_i, .cyc_i, .stb_i, .ack_o, .meas_valid_i, .pin_oe_n_o,
   .trigger_o, .teach_o, .eval_valid_o);
`default_nettype wire

// ==== dv/testbench.sv ====
// Self-checking bench for the switching IO block.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin \
   check_count++; \
   if ((g) !== (e)) begin \
      err_total++; \
      $display("unexpected %s: expected %0h seen %0h", nm, e, g); \
   end \
end
module testbench;
   import swio_pkg::*;
   logic clk_i, rst_i, we_i, cyc_i, stb_i, ack_o, meas_valid_i, warn_i;
   logic [7:0]  adr_i;
   logic [31:0] dat_i, dat_o, r;
   logic [3:0]  sel_i, pin_i, pin_o, pin_oe_n_o, drive;
   logic [10:0] meas_first_i, meas_last_i, meas_cnt_i;
   logic trigger_o, teach_o, eval_valid_o, t, h;
   int err_total, check_count;
   swio_top u_dut (.clk_i, .rst_i, .adr_i, .dat_i, .dat_o, .we_i, .sel_i,
      .cyc_i, .stb_i, .ack_o, .meas_valid_i, .meas_first_i, .meas_last_i,
      .meas_cnt_i, .warn_i, .pin_i, .pin_o, .pin_oe_n_o, .trigger_o,
      .teach_o, .eval_valid_o);
   ctrl_model u_ctrl (.dev_lvl_i(pin_o), .dev_oe_n_i(pin_oe_n_o),
      .wire_o(pin_i), .drive_i(drive));
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : end_of_test
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      dat_i <= d;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_o !== 1'b1 && n < 16);
      if (n >= 16) begin
         err_total++;
         end_of_test();
      end
      r = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
   endtask : wb
   task automatic rdm(input string nm, input logic [7:0] a,
                      input logic [31:0] m, input logic [31:0] e);
      wb(1'b0, a, 32'h0000_0000);
      `CHK(nm, e, r & m);
   endtask : rdm
   task automatic meas(input logic [10:0] f, input logic [10:0] l,
                       input logic [10:0] c);
      @(posedge clk_i);
      meas_valid_i <= 1'b1;
      meas_first_i <= f;
      meas_last_i <= l;
      meas_cnt_i <= c;
      @(posedge clk_i);
      meas_valid_i <= 1'b0;
      repeat (2) @(posedge clk_i);
   endtask : meas
   task automatic pin_ev(input int p, input logic lvl);
      @(posedge clk_i);
      drive[p] <= lvl;
      t = 1'b0;
      h = 1'b0;
      repeat (10) begin
         @(posedge clk_i);
         t |= trigger_o;
         h |= teach_o;
      end
   endtask : pin_ev
   function automatic logic [7:0] pa(input int p, input int w);
      return 8'h10 + 8'(16 * p + 4 * w);
   endfunction : pa
   initial begin
      clk_i = 1'b0;
      forever #2 clk_i = ~clk_i;
   end
   initial begin
      {rst_i, warn_i, sel_i} = 6'h3F;
      {we_i, cyc_i, stb_i, meas_valid_i} = 4'h0;
      {adr_i, dat_i, drive} = '0;
      {meas_first_i, meas_last_i, meas_cnt_i} = '0;
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      rdm("ctrl", ADR_CTRL, 32'hFFFF_FFFF, 32'h0000_0000);
      rdm("depth", ADR_DEPTH, 32'h0000_00FF, 32'h0000_0001);
      rdm("cfg", pa(0, 0), 32'h0000_001F, 32'h0000_0000);
      rdm("start", pa(0, 1), 32'h0000_07FF, 32'h0000_0001);
      rdm("end", pa(0, 2), 32'h0000_07FF, 32'h0000_06EE);
      wb(1'b1, 8'h50, 32'h0000_FFFF);
      rdm("unmapped", 8'h50, 32'hFFFF_FFFF, 32'h0000_0000);
      $display("test reset and map done");
      pin_ev(0, 1'b1);
      `CHK("trigger", 2'b10, {t, h});
      pin_ev(0, 1'b0);
      `CHK("trigger fall", 1'b0, t);
      pin_ev(0, 1'b1);
      wb(1'b1, ADR_CTRL, 32'h0000_0001);
      meas(11'h001, 11'h001, 11'h000);
      pin_ev(0, 1'b0);
      `CHK("sink trigger", 1'b1, t);
      pin_ev(0, 1'b1);
      `CHK("sink rise", 1'b0, t);
      wb(1'b1, ADR_CTRL, 32'h0000_0000);
      wb(1'b1, pa(3, 0), 32'(FN_TEACH_IN));
      meas(11'h001, 11'h001, 11'h000);
      pin_ev(0, 1'b0);
      pin_ev(3, 1'b1);
      `CHK("teach", 2'b01, {t, h});
      $display("test input functions done");
      wb(1'b1, ADR_DEPTH, 32'h0000_0000);
      rdm("depth rej", ADR_STATUS, 32'h0000_0002, 32'h0000_0002);
      wb(1'b1, ADR_DEPTH, 32'h0000_0100);
      rdm("depth kept", ADR_DEPTH, 32'h0000_00FF, 32'h0000_0001);
      wb(1'b1, ADR_DEPTH, 32'h0000_00FF);
      rdm("depth max", ADR_DEPTH, 32'h0000_00FF, 32'h0000_00FF);
      wb(1'b1, ADR_DEPTH, 32'h0000_0003);
      `CHK("eval clear", 1'b0, eval_valid_o);
      repeat (2) meas(11'h004, 11'h009, 11'h006);
      `CHK("eval early", 1'b0, eval_valid_o);
      rdm("count", ADR_STATUS, 32'h0000_FF00, 32'h0000_0200);
      meas(11'h004, 11'h009, 11'h006);
      `CHK("eval", 1'b1, eval_valid_o);
      rdm("eval stat", ADR_STATUS, 32'h0000_FF01, 32'h0000_0301);
      wb(1'b1, ADR_DEPTH, 32'h0000_0001);
      `CHK("eval restart", 1'b0, eval_valid_o);
      rdm("count clr", ADR_STATUS, 32'h0000_FF00, 32'h0000_0000);
      wb(1'b1, ADR_STATUS, 32'h0000_0006);
      wb(1'b1, pa(0, 1), 32'h0000_06EF);
      rdm("beam rej", ADR_STATUS, 32'h0000_0006, 32'h0000_0004);
      wb(1'b1, pa(0, 1), 32'h0000_0000);
      rdm("start kept", pa(0, 1), 32'h0000_07FF, 32'h0000_0001);
      wb(1'b1, pa(0, 1), 32'h0000_06EE);
      rdm("start max", pa(0, 1), 32'h0000_07FF, 32'h0000_06EE);
      $display("test limits done");
      wb(1'b1, pa(1, 2), 32'h0000_0020);
      wb(1'b1, pa(1, 1), 32'h0000_0001);
      for (int k = 0; k < 4; k++) begin
         wb(1'b1, ADR_CTRL, 32'(k / 2));
         wb(1'b1, pa(1, 0), 32'h0000_0012 | 32'((k % 2) * 8));
         meas(11'h005, 11'h00A, 11'h006);
         `CHK("area on", 1'(1 ^ k / 2 ^ k % 2), pin_o[1]);
         meas(11'h064, 11'h0C8, 11'h065);
         `CHK("area off", 1'(k / 2 ^ k % 2), pin_o[1]);
      end
      wb(1'b1, ADR_CTRL, 32'h0000_0000);
      for (int f = 0; f <= 4; f++) begin
         wb(1'b1, pa(2, 0), 32'(f));
         `CHK("dir hold", 1'(f <= 2), pin_oe_n_o[2]);
         meas(11'h064, 11'h0C8, 11'h065);
         `CHK("dir", 1'(f < 2), pin_oe_n_o[2]);
         if (f == 3) `CHK("warn", 1'b1, pin_i[2]);
         if (f == 4) `CHK("trig out", 1'b1, pin_o[2]);
      end
      wb(1'b1, pa(2, 0), 32'h0000_0012);
      meas(11'h028, 11'h032, 11'h00B);
      wb(1'b1, ADR_CMD, 32'h0000_0004);
      rdm("taught start", pa(2, 1), 32'h0000_07FF, 32'h0000_0028);
      rdm("taught end", pa(2, 2), 32'h0000_07FF, 32'h0000_0032);
      meas(11'h02D, 11'h02D, 11'h001);
      `CHK("taught on", 1'b1, pin_o[2]);
      meas(11'h064, 11'h064, 11'h001);
      `CHK("taught off", 1'b0, pin_o[2]);
      $display("test outputs done");
      end_of_test();
   end
endmodule : testbench
`default_nettype wire

// ==== rtl/swio_pkg.sv ====
// Package with the register map, field layout and limits of the switching IO.
package swio_pkg;
// Notes on behaviour
// (R01) A pin may act as trigger input.
// (R02) A pin may act as teach input.
// (R03) Polarity selects source or sink switching.
// (R04) Teach execute captures detected height as area.
// (R05) Taught height becomes the pin's area.
// (R06) Controller must also select area output function.
// (R07) Inversion flips output sense: light or dark.
// (R08) Evaluate only after beam states stay stable.
// (R09) Depth N needs N agreeing cycles.
// (R10) Depth 1 to 255 accepted, others rejected.
// (R11) Beams 1 to 1774 accepted, others rejected.
// (R12) Config changes apply from next measurement cycle.
// (R13) Depth change restarts the consistency count.

   localparam int NPINS  = 4;
   localparam int AW     = 8;
   localparam int BEAM_W = 11;
   localparam int DEPTH_W = 8;

   // Register byte addresses.
   localparam logic [7:0] ADR_CTRL   = 8'h00;
   localparam logic [7:0] ADR_DEPTH  = 8'h04;
   localparam logic [7:0] ADR_STATUS = 8'h08;
   localparam logic [7:0] ADR_CMD    = 8'h0C;
   // Pin blocks start at 0x10, one 16-byte block per pin.
   localparam logic [3:0] PIN_BLK_FIRST = 4'h1;
   localparam logic [1:0] PW_CFG   = 2'h0;
   localparam logic [1:0] PW_START = 2'h1;
   localparam logic [1:0] PW_END   = 2'h2;

   // Pin function codes.
   localparam logic [2:0] FN_TRIG_IN  = 3'h0;
   localparam logic [2:0] FN_TEACH_IN = 3'h1;
   localparam logic [2:0] FN_AREA_OUT = 3'h2;
   localparam logic [2:0] FN_WARN_OUT = 3'h3;
   localparam logic [2:0] FN_TRIG_OUT = 3'h4;

   // Field positions.
   localparam int CTRL_NPN_BIT  = 0;
   localparam int CFG_FN_LSB    = 0;
   localparam int CFG_INV_BIT   = 3;
   localparam int CFG_OR_BIT    = 4;
   localparam int STAT_EVAL_BIT = 0;
   localparam int STAT_DREJ_BIT = 1;
   localparam int STAT_BREJ_BIT = 2;
   localparam int STAT_CNT_LSB  = 8;

   // Accepted ranges.
   localparam logic [15:0] DEPTH_MIN = 16'h0001;
   localparam logic [15:0] DEPTH_MAX = 16'h00FF;
   localparam logic [15:0] BEAM_MIN  = 16'h0001;
   localparam logic [15:0] BEAM_MAX  = 16'h06EE;

   // Reset values.
   localparam logic [DEPTH_W-1:0] DEPTH_RST = 8'h01;
   localparam logic [BEAM_W-1:0]  START_RST = 11'h001;
   localparam logic [BEAM_W-1:0]  END_RST   = 11'h6EE;
   localparam logic [2:0]         FN_RST    = FN_TRIG_IN;
endpackage : swio_pkg

// ==== rtl/swio_top.sv ====
// Switching IO block with filter depth stage and Wishbone register slave.
//
// Decided for this implementation: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module swio_top (
   // Clock and reset
   input  wire logic                          clk_i,
   input  wire logic                          rst_i,
   // Wishbone slave
   input  wire logic [swio_pkg::AW-1:0]       adr_i,
   input  wire logic [31:0]                   dat_i,
   output logic      [31:0]                   dat_o,
   input  wire logic                          we_i,
   input  wire logic [3:0]                    sel_i,
   input  wire logic                          cyc_i,
   input  wire logic                          stb_i,
   output logic                               ack_o,
   // Measurement results
   input  wire logic                          meas_valid_i,
   input  wire logic [swio_pkg::BEAM_W-1:0]   meas_first_i,
   input  wire logic [swio_pkg::BEAM_W-1:0]   meas_last_i,
   input  wire logic [swio_pkg::BEAM_W-1:0]   meas_cnt_i,
   input  wire logic                          warn_i,
   // Switching pins
   input  wire logic [swio_pkg::NPINS-1:0]    pin_i,
   output logic      [swio_pkg::NPINS-1:0]    pin_o,
   output logic      [swio_pkg::NPINS-1:0]    pin_oe_n_o,
   // Events and state
   output logic                               trigger_o,
   output logic                               teach_o,
   output logic                               eval_valid_o
);
   import swio_pkg::*;

   localparam logic [3:0] NPINS4 = 4'(NPINS);

   // Bus decode.
   logic       acc, wr, lo_ok, in_pin;
   logic [3:0] pin_sel;
   logic [1:0] pidx, pword;
   logic [15:0] wlo;
   logic        depth_ok, beam_ok;

   assign acc      = cyc_i & stb_i & ~ack_o;
   assign wr       = acc & we_i;
   assign lo_ok    = sel_i[0] & sel_i[1];
   assign pin_sel  = adr_i[7:4] - PIN_BLK_FIRST;
   assign in_pin   = (pin_sel < NPINS4);
   assign pidx     = pin_sel[1:0];
   assign pword    = adr_i[3:2];
   assign wlo      = dat_i[15:0];
   assign depth_ok = (wlo >= DEPTH_MIN) && (wlo <= DEPTH_MAX); // R10
   assign beam_ok  = (wlo >= BEAM_MIN) && (wlo <= BEAM_MAX); // R11

   // Software registers.
   logic                           npn_q, npn_d;
   logic [DEPTH_W-1:0]             depth_q, depth_d;
   logic                           drej_q, drej_d, brej_q, brej_d;
   logic [NPINS-1:0][2:0]          func_q, func_d;
   logic [NPINS-1:0]               inv_q, inv_d, or_q, or_d;
   logic [NPINS-1:0][BEAM_W-1:0]   start_q, start_d, end_q, end_d;
   logic                           depth_chg;
   logic [31:0]                    rdat;

   // Active copies and filter state.
   logic                           npn_a_q, npn_a_d;
   logic [NPINS-1:0][2:0]          func_a_q, func_a_d;
   logic [NPINS-1:0]               inv_a_q, inv_a_d;
   logic [BEAM_W-1:0]              pf_q, pf_d, pl_q, pl_d, pc_q, pc_d;
   logic [BEAM_W-1:0]              ef_q, ef_d, el_q, el_d, ec_q, ec_d;
   logic [DEPTH_W-1:0]             cons_q, cons_d;
   logic                           evv_q, evv_d, evt_q, evt_d;
   logic [NPINS-1:0]               area_q, area_d, hit;
   logic                           same;
   logic [NPINS-1:0]               ptrig, pteach;

   // Register access.
   always_comb begin
      npn_d     = npn_q;
      depth_d   = depth_q;
      drej_d    = drej_q;
      brej_d    = brej_q;
      func_d    = func_q;
      inv_d     = inv_q;
      or_d      = or_q;
      start_d   = start_q;
      end_d     = end_q;
      depth_chg = 1'b0;
      rdat      = 32'h0000_0000;
      if (wr && adr_i == ADR_CTRL && sel_i[0]) begin
         npn_d = dat_i[CTRL_NPN_BIT]; // R03
      end
      if (wr && adr_i == ADR_DEPTH && lo_ok) begin
         if (depth_ok) begin
            depth_d   = wlo[DEPTH_W-1:0]; // R10
            depth_chg = 1'b1;
         end else begin
            drej_d = 1'b1; // R10
         end
      end
      if (wr && adr_i == ADR_STATUS && sel_i[0]) begin
         if (dat_i[STAT_DREJ_BIT]) begin
            drej_d = 1'b0;
         end
         if (dat_i[STAT_BREJ_BIT]) begin
            brej_d = 1'b0;
         end
      end
      if (wr && adr_i == ADR_CMD && sel_i[0]) begin
         for (int p = 0; p < NPINS; p++) begin
            if (dat_i[p] && evv_q && ec_q != '0) begin
               start_d[p] = ef_q; // R04
               end_d[p]   = el_q; // R05
            end
         end
      end
      if (wr && in_pin && pword == PW_CFG && sel_i[0]) begin
         func_d[pidx] = dat_i[CFG_FN_LSB +: 3]; // R01 R02
         inv_d[pidx]  = dat_i[CFG_INV_BIT]; // R07
         or_d[pidx]   = dat_i[CFG_OR_BIT];
      end
      if (wr && in_pin && (pword == PW_START || pword == PW_END)
          && lo_ok) begin
         if (!beam_ok) begin
            brej_d = 1'b1; // R11
         end else if (pword == PW_START) begin
            start_d[pidx] = wlo[BEAM_W-1:0];
         end else begin
            end_d[pidx] = wlo[BEAM_W-1:0];
         end
      end
      if (adr_i == ADR_CTRL) begin
         rdat[CTRL_NPN_BIT] = npn_q;
      end else if (adr_i == ADR_DEPTH) begin
         rdat[DEPTH_W-1:0] = depth_q;
      end else if (adr_i == ADR_STATUS) begin
         rdat[STAT_EVAL_BIT] = evv_q;
         rdat[STAT_DREJ_BIT] = drej_q;
         rdat[STAT_BREJ_BIT] = brej_q;
         rdat[STAT_CNT_LSB +: DEPTH_W] = cons_q;
      end else if (in_pin && pword == PW_CFG) begin
         rdat[CFG_FN_LSB +: 3] = func_q[pidx];
         rdat[CFG_INV_BIT]     = inv_q[pidx];
         rdat[CFG_OR_BIT]      = or_q[pidx];
      end else if (in_pin && pword == PW_START) begin
         rdat[BEAM_W-1:0] = start_q[pidx];
      end else if (in_pin && pword == PW_END) begin
         rdat[BEAM_W-1:0] = end_q[pidx];
      end
   end

   // Area hit test per pin on the incoming measurement.
   genvar g;
   generate
      for (g = 0; g < NPINS; g++) begin : g_pin
         logic any_in, all_in;
         logic [BEAM_W-1:0] span;
         assign span   = BEAM_W'(meas_last_i - meas_first_i + 1'b1);
         assign any_in = (meas_cnt_i != '0) && (meas_first_i <= end_q[g])
                         && (meas_last_i >= start_q[g]);
         assign all_in = (meas_cnt_i != '0) && (meas_first_i <= start_q[g])
                         && (meas_last_i >= end_q[g]) && (meas_cnt_i == span);
         assign hit[g] = or_q[g] ? any_in : all_in;

         switch_pin u_pin (
            .clk_i      (clk_i),
            .rst_i      (rst_i),
            .npn_i      (npn_a_q),
            .inv_i      (inv_a_q[g]),
            .func_i     (func_a_q[g]),
            .area_i     (area_q[g]),
            .warn_i     (warn_i),
            .pulse_i    (evt_q),
            .pin_i      (pin_i[g]),
            .pin_o      (pin_o[g]),
            .pin_oe_n_o (pin_oe_n_o[g]),
            .trig_o     (ptrig[g]),
            .teach_o    (pteach[g])
         );
      end
   endgenerate

   // Filter depth stage and configuration hand-over.
   always_comb begin
      npn_a_d  = npn_a_q;
      func_a_d = func_a_q;
      inv_a_d  = inv_a_q;
      pf_d     = pf_q;
      pl_d     = pl_q;
      pc_d     = pc_q;
      ef_d     = ef_q;
      el_d     = el_q;
      ec_d     = ec_q;
      cons_d   = cons_q;
      evv_d    = evv_q;
      evt_d    = 1'b0;
      area_d   = area_q;
      same     = (meas_first_i == pf_q) && (meas_last_i == pl_q)
                 && (meas_cnt_i == pc_q);
      if (meas_valid_i) begin
         npn_a_d  = npn_q; // R12
         func_a_d = func_q; // R12
         inv_a_d  = inv_q; // R12
         pf_d     = meas_first_i;
         pl_d     = meas_last_i;
         pc_d     = meas_cnt_i;
      end
      if (depth_chg) begin
         cons_d = '0; // R13
         evv_d  = 1'b0; // R13
      end else if (meas_valid_i) begin
         if (!same) begin
            cons_d = DEPTH_W'(1); // R08
         end else if (cons_q < depth_q) begin
            cons_d = DEPTH_W'(cons_q + 1'b1); // R09
         end
         if (cons_d >= depth_q) begin
            evv_d  = 1'b1; // R08
            evt_d  = 1'b1;
            ef_d   = meas_first_i;
            el_d   = meas_last_i;
            ec_d   = meas_cnt_i;
            area_d = hit;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o        <= 1'b0;
         dat_o        <= 32'h0000_0000;
         npn_q        <= 1'b0;
         depth_q      <= DEPTH_RST;
         drej_q       <= 1'b0;
         brej_q       <= 1'b0;
         func_q       <= {NPINS{FN_RST}};
         inv_q        <= '0;
         or_q         <= '0;
         start_q      <= {NPINS{START_RST}};
         end_q        <= {NPINS{END_RST}};
         npn_a_q      <= 1'b0;
         func_a_q     <= {NPINS{FN_RST}};
         inv_a_q      <= '0;
         pf_q         <= '0;
         pl_q         <= '0;
         pc_q         <= '0;
         ef_q         <= '0;
         el_q         <= '0;
         ec_q         <= '0;
         cons_q       <= '0;
         evv_q        <= 1'b0;
         evt_q        <= 1'b0;
         area_q       <= '0;
         trigger_o    <= 1'b0;
         teach_o      <= 1'b0;
         eval_valid_o <= 1'b0;
      end else begin
         ack_o        <= acc;
         dat_o        <= (acc && !we_i) ? rdat : 32'h0000_0000;
         npn_q        <= npn_d;
         depth_q      <= depth_d;
         drej_q       <= drej_d;
         brej_q       <= brej_d;
         func_q       <= func_d;
         inv_q        <= inv_d;
         or_q         <= or_d;
         start_q      <= start_d;
         end_q        <= end_d;
         npn_a_q      <= npn_a_d;
         func_a_q     <= func_a_d;
         inv_a_q      <= inv_a_d;
         pf_q         <= pf_d;
         pl_q         <= pl_d;
         pc_q         <= pc_d;
         ef_q         <= ef_d;
         el_q         <= el_d;
         ec_q         <= ec_d;
         cons_q       <= cons_d;
         evv_q        <= evv_d;
         evt_q        <= evt_d;
         area_q       <= area_d;
         trigger_o    <= |ptrig; // R01
         teach_o      <= |pteach; // R02
         eval_valid_o <= evv_d;
      end
   end
endmodule : swio_top
`default_nettype wire

// ==== rtl/switch_pin.sv ====
// One switching pin: input sync, edge detect and registered output drive.
`timescale 1ns/1ps
`default_nettype none
module switch_pin (
   // Clock and reset
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   // Configuration
   input  wire logic       npn_i,
   input  wire logic       inv_i,
   input  wire logic [2:0] func_i,
   // Output sources
   input  wire logic       area_i,
   input  wire logic       warn_i,
   input  wire logic       pulse_i,
   // Pin
   input  wire logic       pin_i,
   output logic            pin_o,
   output logic            pin_oe_n_o,
   // Events
   output logic            trig_o,
   output logic            teach_o
);
   import swio_pkg::*;

   logic s1_q, s2_q, s3_q;
   logic pin_d, oe_n_d, trig_d, teach_d;
   logic act, act_prev, rise, st, drv, lvl;

   always_comb begin
      act      = npn_i ? ~s2_q : s2_q; // R03
      act_prev = npn_i ? ~s3_q : s3_q;
      rise     = act & ~act_prev;
      trig_d   = 1'b0;
      teach_d  = 1'b0;
      st       = 1'b0;
      drv      = 1'b0;
      case (func_i)
         FN_TRIG_IN: begin
            trig_d = rise; // R01
         end
         FN_TEACH_IN: begin
            teach_d = rise; // R02
         end
         FN_AREA_OUT: begin
            st  = area_i; // R06
            drv = 1'b1;
         end
         FN_WARN_OUT: begin
            st  = warn_i;
            drv = 1'b1;
         end
         FN_TRIG_OUT: begin
            st  = pulse_i;
            drv = 1'b1;
         end
         default: begin
            drv = 1'b0;
         end
      endcase
      lvl    = st ^ inv_i; // R07
      pin_d  = npn_i ? ~lvl : lvl; // R03
      oe_n_d = ~drv;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s1_q       <= 1'b0;
         s2_q       <= 1'b0;
         s3_q       <= 1'b0;
         pin_o      <= 1'b0;
         pin_oe_n_o <= 1'b1;
         trig_o     <= 1'b0;
         teach_o    <= 1'b0;
      end else begin
         s1_q       <= pin_i;
         s2_q       <= s1_q;
         s3_q       <= s2_q;
         pin_o      <= pin_d;
         pin_oe_n_o <= oe_n_d;
         trig_o     <= trig_d;
         teach_o    <= teach_d;
      end
   end
endmodule : switch_pin
`default_nettype wire
